// >>> rts_host.sv
// Host-side sequencer that moves the line switch from ringing to talk
//
// How it works
// - Make-before-break: select goes ringing straight to talk
// - Break-before-make: drive all-off encoding to end ringing
// - Hold all-off at least half a ringing cycle
// - Then apply talk encoding, both selects low
`timescale 1ns/100ps
`default_nettype none
`include "rts_regs.svh"
module rts_host
#(
  parameter int unsigned HOLD_CYCLES = `RTS_HALF_RING_CYC  // Half ringing cycle in clocks
)
(
  input  wire logic                      clk_in,
  input  wire logic                      reset_n_in,
  input  wire logic [`RTS_ADDR_W-1:0]    addr_in,
  input  wire logic [`RTS_DATA_W-1:0]    wdata_in,
  input  wire logic                      wr_in,
  input  wire logic                      rd_in,
  output logic      [`RTS_DATA_W-1:0]    rdata_out,
  output logic                           ring_select_out,
  output logic                           test_select_out,
  output logic                           latch_hold_out,
  input  wire logic                      thermal_shutdown_io_in,
  output logic                           thermal_shutdown_io_out,
  output logic                           thermal_shutdown_io_oe_out
);

  rts_tmr_if tmr_bus ();  // Hold timer link

  rts_hold_timer #(.CYCLES(HOLD_CYCLES)) u_timer
  (
    .clk_in     (clk_in),
    .reset_n_in (reset_n_in),
    .tmr        (tmr_bus.tmr)
  );

  // Address match helper used by both read and write decode
  function automatic logic hit(input logic [`RTS_ADDR_W-1:0] a, input logic [`RTS_ADDR_W-1:0] off);
    hit = (a == off);
  endfunction : hit

  rts_pkg::rts_state_e          state_reg;   // Sequencer state
  rts_pkg::rts_state_e          state_next;
  rts_pkg::rts_mode_e           mode_reg;    // Chosen release technique
  rts_pkg::rts_mode_e           mode_next;
  logic [1:0]                   sel_reg;     // {ring, test} select pins
  logic [1:0]                   sel_next;
  logic                         latch_reg;   // Hold pin level
  logic                         latch_next;
  logic                         sd_low_reg;  // Pulling shutdown line low
  logic                         sd_low_next;
  logic                         done_reg;    // Sticky transition-finished flag
  logic                         done_next;
  logic                         fault_reg;   // Sticky line-low-seen flag
  logic                         fault_next;
  logic [`RTS_DATA_W-1:0]       rdata_reg;   // Read data, one cycle after strobe
  logic [`RTS_DATA_W-1:0]       rdata_next;
  logic                         start_pulse; // Timer start
  logic                         wr_sel;      // Write to select register
  logic                         wr_ctrl;     // Write to control register
  logic                         rd_stat;     // Read of status register

  assign wr_sel  = wr_in && hit(addr_in, `RTS_OFF_SELECT);
  assign wr_ctrl = wr_in && hit(addr_in, `RTS_OFF_CTRL);
  assign rd_stat = rd_in && hit(addr_in, `RTS_OFF_STATUS);

  // Sequencer and register next values
  always_comb
  begin
    state_next  = state_reg;
    mode_next   = mode_reg;
    sel_next    = sel_reg;
    latch_next  = latch_reg;
    sd_low_next = sd_low_reg;
    done_next   = done_reg;
    fault_next  = fault_reg;
    start_pulse = 1'b0;
    // Hold level is software's; low lets selects flow through
    if (wr_ctrl)
    begin
      latch_next = wdata_in[`RTS_CTRL_LATCH_BIT];
    end
    // Reading status clears done; a set in the same cycle wins below
    if (rd_stat)
    begin
      done_next  = 1'b0;
      fault_next = 1'b0;
    end
    // Line low while we do not pull it means the device shut down
    if (!thermal_shutdown_io_in && !sd_low_reg)
    begin
      fault_next = 1'b1;
    end
    case (state_reg)
      rts_pkg::RTS_ST_IDLE:
      begin
        // Direct select writes only while no sequence runs
        if (wr_sel)
        begin
          sel_next = wdata_in[1:0];
        end
        if (wr_ctrl && wdata_in[`RTS_CTRL_START_BIT])
        begin
          mode_next = rts_pkg::rts_mode_e'(wdata_in[`RTS_CTRL_MODE_LSB +: 2]);
          case (rts_pkg::rts_mode_e'(wdata_in[`RTS_CTRL_MODE_LSB +: 2]))
            rts_pkg::RTS_MODE_MBB:
            begin
              // Straight to talk, no intermediate encoding
              sel_next  = `RTS_SEL_TALK;
              done_next = 1'b1;
            end
            rts_pkg::RTS_MODE_BBM_SD:
            begin
              // Pull line low; selects already moved to talk meanwhile
              sd_low_next = 1'b1;
              sel_next    = `RTS_SEL_TALK;
              start_pulse = 1'b1;
              state_next  = rts_pkg::RTS_ST_SDLOW;
            end
            default:
            begin
              // End ringing with the all-off encoding
              sel_next    = `RTS_SEL_ALLOFF;
              start_pulse = 1'b1;
              state_next  = rts_pkg::RTS_ST_ALLOFF;
            end
          endcase
        end
      end
      rts_pkg::RTS_ST_ALLOFF:
      begin
        // Injection switch opens on a zero crossing within this hold
        if (tmr_bus.done)
        begin
          // Talk only now, so break switches close after ringing opened
          sel_next   = `RTS_SEL_TALK;
          done_next  = 1'b1;
          state_next = rts_pkg::RTS_ST_IDLE;
        end
      end
      rts_pkg::RTS_ST_SDLOW:
      begin
        // Release line; device pull-up then closes break switches
        if (tmr_bus.done)
        begin
          sd_low_next = 1'b0;
          done_next   = 1'b1;
          state_next  = rts_pkg::RTS_ST_IDLE;
        end
      end
      default:
      begin
        state_next = rts_pkg::RTS_ST_IDLE;
      end
    endcase
  end

  // Read mux; unmapped addresses read zero
  always_comb
  begin
    rdata_next = '0;
    if (rd_in)
    begin
      case (addr_in)
        `RTS_OFF_SELECT: rdata_next = {30'h0, sel_reg};
        `RTS_OFF_CTRL:   rdata_next = {28'h0, latch_reg, 1'b0, mode_reg};
        `RTS_OFF_STATUS:
        begin
          rdata_next[`RTS_STAT_BUSY_BIT]  = (state_reg != rts_pkg::RTS_ST_IDLE);
          rdata_next[`RTS_STAT_DONE_BIT]  = done_reg;
          rdata_next[`RTS_STAT_FAULT_BIT] = fault_reg;
          rdata_next[`RTS_STAT_LINE_BIT]  = thermal_shutdown_io_in;
        end
        `RTS_OFF_HOLD:   rdata_next = HOLD_CYCLES;
        default:         rdata_next = '0;
      endcase
    end
  end

  // Register stage; selects reset to all-off, hold high (device locked)
  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      state_reg  <= rts_pkg::RTS_ST_IDLE;
      mode_reg   <= rts_pkg::RTS_MODE_MBB;
      sel_reg    <= `RTS_SELECT_RESET;
      latch_reg  <= `RTS_LATCH_RESET;
      sd_low_reg <= 1'b0;
      done_reg   <= 1'b0;
      fault_reg  <= 1'b0;
      rdata_reg  <= '0;
    end
    else
    begin
      state_reg  <= state_next;
      mode_reg   <= mode_next;
      sel_reg    <= sel_next;
      latch_reg  <= latch_next;
      sd_low_reg <= sd_low_next;
      done_reg   <= done_next;
      fault_reg  <= fault_next;
      rdata_reg  <= rdata_next;
    end
  end

  assign tmr_bus.start              = start_pulse;
  assign rdata_out                  = rdata_reg;
  assign ring_select_out            = sel_reg[1];
  assign test_select_out            = sel_reg[0];
  assign latch_hold_out             = latch_reg;
  // Open drain: only ever drive low, never high
  assign thermal_shutdown_io_out    = 1'b0;
  assign thermal_shutdown_io_oe_out = sd_low_reg;

endmodule : rts_host
`default_nettype wire

// >>> rts_regs.svh
// Register offsets, field positions, reset values and timing figures of the ring-to-talk controller
`ifndef RTS_REGS_SVH
`define RTS_REGS_SVH

`define RTS_ADDR_W          4
`define RTS_DATA_W          32
`define RTS_OFF_SELECT      4'h0
`define RTS_OFF_CTRL        4'h4
`define RTS_OFF_STATUS      4'h8
`define RTS_OFF_HOLD        4'hc

`define RTS_CTRL_MODE_LSB   0
`define RTS_CTRL_START_BIT  2
`define RTS_CTRL_LATCH_BIT  3

`define RTS_STAT_BUSY_BIT   0
`define RTS_STAT_DONE_BIT   1
`define RTS_STAT_FAULT_BIT  2
`define RTS_STAT_LINE_BIT   3

`define RTS_SEL_TALK        2'h0
`define RTS_SEL_TEST        2'h1
`define RTS_SEL_RING        2'h2
`define RTS_SEL_ALLOFF      2'h3
`define RTS_SELECT_RESET    2'h3
`define RTS_LATCH_RESET     1'b1

`define RTS_CLK_PERIOD_NS   25
`define RTS_HALF_RING_NS    25000000
`define RTS_HALF_RING_CYC   ((`RTS_HALF_RING_NS + `RTS_CLK_PERIOD_NS - 1) / `RTS_CLK_PERIOD_NS)

`endif

// >>> rts_pkg.sv
// Types shared by the ring-to-talk controller modules
`default_nettype none
package rts_pkg;

  // Release technique chosen by software
  typedef enum logic [1:0]
  {
    RTS_MODE_MBB    = 2'b00,
    RTS_MODE_BBM    = 2'b01,
    RTS_MODE_BBM_SD = 2'b10,
    RTS_MODE_RSVD   = 2'b11
  } rts_mode_e;

  // Sequencer states
  typedef enum logic [1:0]
  {
    RTS_ST_IDLE   = 2'b00,
    RTS_ST_ALLOFF = 2'b01,
    RTS_ST_SDLOW  = 2'b10
  } rts_state_e;

endpackage : rts_pkg
`default_nettype wire

// >>> rts_tmr_if.sv
// Start and done signals between the sequencer and its hold timer
`timescale 1ns/100ps
`default_nettype none
interface rts_tmr_if;
  logic start;  // One-cycle start of a hold period
  logic done;   // One-cycle end of the hold period

  modport ctl (output start, input done);
  modport tmr (input start, output done);
endinterface : rts_tmr_if
`default_nettype wire

// >>> rts_hold_timer.sv
// Half-ringing-cycle hold timer
`timescale 1ns/100ps
`default_nettype none
module rts_hold_timer
#(
  parameter int unsigned CYCLES = 1000000  // Hold length in clocks
)
(
  input  wire logic  clk_in,
  input  wire logic  reset_n_in,
  rts_tmr_if.tmr     tmr
);

  logic [31:0] count_reg;   // Cycles still to run
  logic [31:0] count_next;
  logic        run_reg;     // Timer active
  logic        run_next;
  logic        done_reg;    // End pulse
  logic        done_next;

  // Next-state of the down counter; a restart while running reloads it
  always_comb
  begin
    count_next = count_reg;
    run_next   = run_reg;
    done_next  = 1'b0;
    if (tmr.start)
    begin
      // Never less than one cycle
      count_next = (CYCLES > 1) ? 32'(CYCLES - 1) : 32'h0000_0000;
      run_next   = 1'b1;
    end
    else if (run_reg)
    begin
      if (count_reg == 32'h0000_0000)
      begin
        run_next  = 1'b0;
        done_next = 1'b1;
      end
      else
      begin
        count_next = count_reg - 32'h0000_0001;
      end
    end
  end

  // Register stage
  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      count_reg <= 32'h0000_0000;
      run_reg   <= 1'b0;
      done_reg  <= 1'b0;
    end
    else
    begin
      count_reg <= count_next;
      run_reg   <= run_next;
      done_reg  <= done_next;
    end
  end

  assign tmr.done = done_reg;

endmodule : rts_hold_timer
`default_nettype wire

// >>> rts_host_props.sv
// Port-level checks of the ring-to-talk controller
`timescale 1ns/100ps
`default_nettype none
module rts_host_props
#(
  parameter int unsigned HOLD_CYCLES = 8  // Half ringing cycle in clocks
)
(
  input  wire logic        clk_in,
  input  wire logic        reset_n_in,
  input  wire logic        rd_in,
  input  wire logic        wr_in,
  input  wire logic [31:0] rdata_out,
  input  wire logic        ring_select_out,
  input  wire logic        test_select_out,
  input  wire logic        latch_hold_out,
  input  wire logic        thermal_shutdown_io_out,
  input  wire logic        thermal_shutdown_io_oe_out
);
  int unsigned cnt_reg;   // Cycles the shutdown line has been pulled low
  int unsigned cnt_next;  // Next count
  default clocking @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);
  // Count low-drive cycles, cleared when the line is let go
  always_comb cnt_next = thermal_shutdown_io_oe_out ? cnt_reg + 1 : 0;
  // Register the count
  always_ff @(posedge clk_in or negedge reset_n_in)
    if (!reset_n_in) cnt_reg <= 0;
    else cnt_reg <= cnt_next;
  // Ringing code on the selects
  sequence s_ringing;
    ring_select_out && !test_select_out;
  endsequence
  // Step from ringing into the all-off code
  sequence s_alloff_in;
    ring_select_out && $rose(test_select_out);
  endsequence
  a_mbb_direct: assert property (s_ringing ##1 !ring_select_out |-> !test_select_out)
    else $error("ringing code left through the test code");
  a_alloff_hold: assert property (s_alloff_in |-> (ring_select_out && test_select_out)[*8])
    else $error("all-off code held too briefly");
  a_alloff_talk: assert property ($fell(ring_select_out) && $past(test_select_out) |-> !test_select_out)
    else $error("all-off code not followed by talk");
  a_sd_talk: assert property (thermal_shutdown_io_oe_out |-> !ring_select_out && !test_select_out)
    else $error("selects not at talk while line held low");
  a_sd_drive_low: assert property (thermal_shutdown_io_oe_out |-> !thermal_shutdown_io_out)
    else $error("shutdown line driven high");
  a_sd_min_hold: assert property ($fell(thermal_shutdown_io_oe_out) |-> cnt_reg >= HOLD_CYCLES)
    else $error("shutdown line released too early");
  a_sd_max_hold: assert property (cnt_reg <= HOLD_CYCLES + 1)
    else $error("shutdown line held too long");
  a_latch_by_write: assert property ($changed(latch_hold_out) |-> $past(wr_in))
    else $error("hold pin moved without a write");
  a_read_idle: assert property (!$past(rd_in) |-> rdata_out == 32'h0)
    else $error("read data outside its cycle");
endmodule : rts_host_props
bind rts_host rts_host_props #(.HOLD_CYCLES(HOLD_CYCLES)) u_props (.clk_in, .reset_n_in, .rd_in, .wr_in,
  .rdata_out, .ring_select_out, .test_select_out, .latch_hold_out, .thermal_shutdown_io_out,
  .thermal_shutdown_io_oe_out);
`default_nettype wire

// >>> rts_line_dev.sv
// Behavioural model of the line switch driven by the controller
`timescale 1ns/100ps
`default_nettype none
module rts_line_dev
(
  input  wire logic       clk_in,
  input  wire logic       zero_in,   // One-cycle ringing current zero
  input  wire logic       ring_in,   // Ringing select pin
  input  wire logic       test_in,   // Test select pin
  input  wire logic       hold_in,   // High keeps the captured code
  input  wire logic       sink_in,   // Controller sinks the line
  input  wire logic       hot_in,    // Forced thermal fault
  output logic            line_out,  // Shutdown line level
  output logic [3:0]      sw_out     // Break, return, inject, test
);
  logic [1:0] cap;         // Captured select code
  logic [1:0] eff;         // Code after the shutdown override
  logic       inj = 1'b0;  // Injection switch, opens on zero current only
  // Pull-up wins unless a party sinks the line
  assign line_out = !(sink_in || hot_in);
  // Transparent while hold is low
  always_latch if (!hold_in) cap <= {ring_in, test_in};
  // Low line forces all-off whatever the latch holds
  assign eff = line_out ? cap : 2'b11;
  // A current switch cannot open mid-cycle, so wait for the zero event
  always_ff @(posedge clk_in)
    if (eff == 2'b10) inj <= 1'b1;
    else if (zero_in) inj <= 1'b0;
  // Limits and clamps are ideal, no analog effects modelled
  assign sw_out = {eff == 2'b00, eff == 2'b10, inj, eff == 2'b01};
endmodule : rts_line_dev
`default_nettype wire

// >>> tb_rts_host.sv
// Self-checking bench of the ring-to-talk controller
`timescale 1ns/100ps
`default_nettype none
`include "rts_regs.svh"
module tb_rts_host;
  localparam int unsigned HC = 8;  // Short hold keeps the run brief
  logic        clk_in = 0, reset_n_in = 0, wr_in = 0, rd_in = 0, zero = 0, hot = 0;
  logic [3:0]  addr_in = 0;
  logic [31:0] wdata_in = 0, rdata_out, rd_val;
  logic        ring, test, hold, oe, sd_out, line;
  logic [3:0]  sw;
  int          bad_count = 0, checks = 0, n;
  // Free-running 40 MHz clock
  always #12.5 clk_in = !clk_in;
  rts_host #(.HOLD_CYCLES(HC)) uut (.clk_in, .reset_n_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out,
    .ring_select_out(ring), .test_select_out(test), .latch_hold_out(hold), .thermal_shutdown_io_in(line),
    .thermal_shutdown_io_out(sd_out), .thermal_shutdown_io_oe_out(oe));
  rts_line_dev dev (.clk_in, .zero_in(zero), .ring_in(ring), .test_in(test), .hold_in(hold),
    .sink_in(oe && !sd_out), .hot_in(hot), .line_out(line), .sw_out(sw));
  // Wait k edges, then step off the edge
  task automatic tick(input int k);
    repeat (k) @(posedge clk_in);
    #1;
  endtask : tick
  // One-cycle register write
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    addr_in  <= a;
    wdata_in <= d;
    wr_in    <= 1'b1;
    tick(1);
    wr_in    <= 1'b0;
    tick(1);
  endtask : wr
  // One-cycle read, data taken in the following cycle only
  task automatic rd(input logic [3:0] a);
    addr_in <= a;
    rd_in   <= 1'b1;
    tick(1);
    rd_in   <= 1'b0;
    rd_val  = rdata_out;
    tick(1);
  endtask : rd
  // Compare and count
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e)
    begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // Ringing current crosses zero
  task automatic zap;
    zero <= 1'b1;
    tick(1);
    zero <= 1'b0;
    tick(1);
  endtask : zap
  // Open the latch and start ringing
  task automatic ring_up;
    wr(`RTS_OFF_CTRL, 32'h0);
    wr(`RTS_OFF_SELECT, 32'h2);
    chk("ringing", 4'b0110, sw);
  endtask : ring_up
  // Reset values and an unmapped read
  task automatic t_reset;
    chk("reset pins", 4'b1110, {ring, test, hold, oe});
    rd(`RTS_OFF_CTRL);
    chk("ctrl", 32'h8, rd_val);
    rd(`RTS_OFF_HOLD);
    chk("hold", HC, rd_val);
    rd(4'h2);
    chk("unmapped", 32'h0, rd_val);
    $display("test reset done");
  endtask : t_reset
  // Ringing straight to talk
  task automatic t_mbb;
    ring_up();
    wr(`RTS_OFF_CTRL, 32'h4);
    chk("mbb selects", 2'b00, {ring, test});
    chk("mbb switches", 4'b1010, sw);
    zap();
    chk("mbb talk", 4'b1000, sw);
    rd(`RTS_OFF_STATUS);
    chk("mbb status", 32'ha, rd_val);
    rd(`RTS_OFF_STATUS);
    chk("status cleared", 32'h8, rd_val);
    $display("test mbb done");
  endtask : t_mbb
  // All-off code held, then talk; a select write while busy is refused
  task automatic t_bbm(input logic [1:0] m);
    ring_up();
    wr(`RTS_OFF_CTRL, {28'h0, 2'b01, m});
    chk("alloff switches", 4'b0010, sw);
    wr(`RTS_OFF_SELECT, 32'h2);
    rd(`RTS_OFF_SELECT);
    chk("select refused", 32'h3, rd_val);
    zap();
    chk("bbm switches", 4'b0000, sw);
    n = 0;
    while (ring && n < 40)
    begin
      tick(1);
      n++;
    end
    chk("hold span", 1'b1, (7 + n >= HC) && (7 + n <= HC + 2));
    chk("bbm talk", 4'b1000, sw);
    rd(`RTS_OFF_STATUS);
    chk("bbm done", 32'h2, rd_val & 32'h3);
    $display("test bbm done");
  endtask : t_bbm
  // All-off through the shutdown line
  task automatic t_alt;
    ring_up();
    wr(`RTS_OFF_CTRL, 32'h6);
    chk("sd switches", 4'b0010, sw);
    zap();
    chk("sd off", 4'b0000, sw);
    rd(`RTS_OFF_STATUS);
    chk("sd busy", 32'h1, rd_val);
    tick(HC);
    chk("sd talk", 4'b1000, sw);
    rd(`RTS_OFF_STATUS);
    chk("sd done", 32'h2, rd_val & 32'h3);
    $display("test alt done");
  endtask : t_alt
  // Hold pin high keeps talk despite a new code
  task automatic t_latch;
    wr(`RTS_OFF_CTRL, 32'h8);
    wr(`RTS_OFF_SELECT, 32'h2);
    chk("latched", 4'b1000, sw);
    wr(`RTS_OFF_CTRL, 32'h0);
    chk("released", 4'b0110, sw);
    wr(`RTS_OFF_SELECT, 32'h0);
    zap();
    $display("test latch done");
  endtask : t_latch
  // Line pulled low by the device shows as a fault
  task automatic t_fault;
    rd(`RTS_OFF_STATUS);
    hot <= 1'b1;
    tick(4);
    rd(`RTS_OFF_STATUS);
    chk("fault", 32'h4, rd_val & 32'hc);
    hot <= 1'b0;
    tick(4);
    $display("test fault done");
  endtask : t_fault
  // Counts and verdict
  task automatic summarize;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : summarize
  // Main sequence
  initial
  begin
    tick(16);
    reset_n_in <= 1'b1;
    tick(1);
    t_reset();
    t_mbb();
    t_bbm(2'd1);
    t_bbm(2'd3);
    t_alt();
    t_latch();
    t_fault();
    summarize();
  end
  // Watchdog, far beyond the hundred or so cycles needed
  initial
  begin
    #(25 * 3000);
    bad_count++;
    summarize();
  end
endmodule : tb_rts_host
`default_nettype wire
